// ===== src/ddrs_sram_port.sv
// ddrs_sram_port: pin behaviour of a burst-of-four sram with separate read and write ports
// assumes clk runs at beat rate; alternate beats stand for input clock and its complement
// Operation
// - write data is captured on both input clock phases during a write burst
// - write select low at a positive input clock edge starts a write
// - with write select high and no write burst running, write data inputs are ignored
// - nibble variant: first select gates bits 3..0, second gates 7..4
// - each active-low byte select gates one 9-bit lane of write data
// - a deselected lane leaves the stored lane unchanged
// - lane selects are sampled on the same beat as their data
// - one shared address bus sampled at positive input clock for both ports
// - address width is 20 bits for the 18-bit configuration
// - address is ignored when the port it would serve is not selected
// - read data driven on output clock phases, or input phases in single mode
// - read data outputs are released when the read port is deselected
// - read select starts a four-beat read burst that completes before release
// - every access starts only on a positive input clock edge
`default_nettype none
module ddrs_sram_port
  import ddrs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic single_clock_mode,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire ddrs_pkg::ddrs_addr_t address,
  input wire ddrs_pkg::ddrs_word_t write_data,
  input wire ddrs_pkg::ddrs_lanes_t byte_lane_write_select_n,
  output ddrs_pkg::ddrs_word_t read_data,
  output logic read_data_oe,
  output logic input_phase_k_n,
  output logic write_room
);
  import ddrs_pkg::*;

  typedef struct packed {
    logic phase;
    logic wr_act;
    logic [BEAT_W-1:0] wr_beat;
    logic [SLOT_ADDR_W-1:0] wr_slot;
    logic rd_act;
    logic [BEAT_W-1:0] rd_beat;
    logic [SLOT_ADDR_W-1:0] rd_slot;
    logic s1_vld;
    ddrs_word_t s1_data;
    logic s2_vld;
    ddrs_word_t s2_data;
    ddrs_word_t q;
    logic q_oe;
    logic room;
    logic [ARRAY_WORDS-1:0][DATA_W-1:0] mem;
  } ddrs_st_t;

  ddrs_st_t st_r;
  ddrs_st_t st_nxt;

  logic k_edge;
  logic wr_start;
  logic rd_start;
  logic push_valid;
  logic push_ready;
  ddrs_entry_t push_entry;
  ddrs_idx_t push_idx;
  logic drain_valid;
  logic drain_ready;
  ddrs_entry_t drain_entry;
  logic [FIFO_CNT_W-1:0] fifo_level;
  ddrs_idx_t drain_idx;
  ddrs_lanes_t drain_lanes_n;
  ddrs_word_t drain_data;
  ddrs_word_t drain_mask;
  ddrs_idx_t rd_idx;

  // expands active-low lane selects into a bit mask of the word
  function automatic ddrs_word_t lane_mask(input ddrs_lanes_t sel_n);
    ddrs_word_t m;
    m = '0;
    if (NIBBLE_CFG) begin
      for (int n = 0; n < LANES; n++) begin
        if (!sel_n[n]) begin
          m[n*NIBBLE_W +: NIBBLE_W] = '1;
        end
      end
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (!sel_n[l]) begin
          m[l*LANE_W +: LANE_W] = '1;
        end
      end
    end
    return m;
  endfunction

  // accesses only open on the beat that stands for the positive input clock
  assign k_edge = (st_r.phase == PHASE_K);

  // a write burst is refused if the fifo cannot take all four beats
  assign wr_start = k_edge && !write_port_select_n && !st_r.wr_act
                    && (fifo_level <= FIFO_START_MAX);
  // read may chain directly onto the last beat of the previous burst
  assign rd_start = k_edge && !read_port_select_n
                    && (!st_r.rd_act || st_r.rd_beat == BEAT_LAST);

  // beat 0 goes with the request cycle, later beats use the held slot
  always_comb begin
    push_idx = '0;
    if (wr_start) begin
      push_idx = {address[SLOT_ADDR_W-1:0], BEAT_FIRST};
    end else begin
      push_idx = {st_r.wr_slot, st_r.wr_beat};
    end
  end

  // data and lane selects travel together, sampled on the same beat
  assign push_valid = wr_start || st_r.wr_act;
  assign push_entry = {push_idx, byte_lane_write_select_n, write_data};

  // draining pauses on a read start so the array sees one access that beat
  assign drain_ready = !rd_start;
  assign drain_idx = drain_entry[ENTRY_W-1 -: WORD_IDX_W];
  assign drain_lanes_n = drain_entry[DATA_W +: LANES];
  assign drain_data = drain_entry[DATA_W-1:0];
  assign drain_mask = lane_mask(drain_lanes_n);

  assign rd_idx = {st_r.rd_slot, st_r.rd_beat};

  ddrs_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH),
    .PTR_W(FIFO_PTR_W),
    .CNT_W(FIFO_CNT_W)
  ) u_wr_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_entry),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_entry),
    .level(fifo_level)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.phase = ~st_r.phase;

    // write port: beat counter runs 1..3 after the request beat
    if (wr_start) begin
      st_nxt.wr_act = 1'b1;
      st_nxt.wr_beat = BEAT_SECOND;
      st_nxt.wr_slot = address[SLOT_ADDR_W-1:0];
    end else if (st_r.wr_act) begin
      st_nxt.wr_beat = st_r.wr_beat + BEAT_W'(1);
      if (st_r.wr_beat == BEAT_LAST) begin
        st_nxt.wr_act = 1'b0;
      end
    end
    // read port: four beats from the latched slot
    if (rd_start) begin
      st_nxt.rd_act = 1'b1;
      st_nxt.rd_beat = BEAT_FIRST;
      st_nxt.rd_slot = address[SLOT_ADDR_W-1:0];
    end else if (st_r.rd_act) begin
      st_nxt.rd_beat = st_r.rd_beat + BEAT_W'(1);
      if (st_r.rd_beat == BEAT_LAST) begin
        st_nxt.rd_act = 1'b0;
      end
    end

    // array read for the current burst beat
    st_nxt.s1_vld = st_r.rd_act;
    st_nxt.s1_data = st_r.rd_act ? st_r.mem[rd_idx] : '0;
    st_nxt.s2_vld = st_r.s1_vld;
    st_nxt.s2_data = st_r.s1_data;

    // single mode launches a beat earlier than the output clock path
    if (single_clock_mode) begin
      st_nxt.q = st_r.s1_data;
      st_nxt.q_oe = st_r.s1_vld;
    end else begin
      st_nxt.q = st_r.s2_data;
      st_nxt.q_oe = st_r.s2_vld;
    end

    // masked merge keeps lanes whose select was high
    if (drain_valid && drain_ready) begin
      st_nxt.mem[drain_idx] = (st_r.mem[drain_idx] & ~drain_mask)
                              | (drain_data & drain_mask);
    end

    st_nxt.room = (fifo_level <= FIFO_START_MAX) && push_ready;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign read_data = st_r.q;
  assign read_data_oe = st_r.q_oe;
  assign input_phase_k_n = st_r.phase;
  assign write_room = st_r.room;
endmodule
`default_nettype wire

// ===== src/ddrs_pkg.sv
// ddrs_pkg: constants and types shared by the sram port model and its write fifo
// assumes one beat clock where alternate cycles stand for the two input clock phases
`default_nettype none
package ddrs_pkg;
  // x18 configuration: 18-bit data, two 9-bit lanes, 20 address bits
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int ADDR_W = 20;
  localparam int NIBBLE_W = 4;
  localparam bit NIBBLE_CFG = 1'b0;
  // four words per address, beat index is the low part of the word index
  localparam int BURST_LEN = 4;
  localparam int BEAT_W = 2;
  localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_SECOND = 2'h1;
  localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
  // modelled array: low address bits select a burst slot in flip-flops
  localparam int SLOT_ADDR_W = 2;
  localparam int WORD_IDX_W = SLOT_ADDR_W + BEAT_W;
  localparam int ARRAY_WORDS = 16;
  // write fifo in the data path
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_PTR_W = 3;
  localparam int FIFO_CNT_W = 4;
  localparam logic [FIFO_CNT_W-1:0] FIFO_START_MAX = 4'h4;
  localparam int ENTRY_W = WORD_IDX_W + LANES + DATA_W;
  // input clock phase: which edge the current beat represents
  localparam logic PHASE_K = 1'b0;
  localparam logic PHASE_K_N = 1'b1;
  typedef logic [DATA_W-1:0] ddrs_word_t;
  typedef logic [ADDR_W-1:0] ddrs_addr_t;
  typedef logic [LANES-1:0] ddrs_lanes_t;
  typedef logic [WORD_IDX_W-1:0] ddrs_idx_t;
  typedef logic [ENTRY_W-1:0] ddrs_entry_t;
endpackage
`default_nettype wire

// ===== src/ddrs_fifo.sv
// ddrs_fifo: flip-flop fifo with valid/ready on both sides and a fill level
// assumes one clock and synchronous active-high reset
`default_nettype none
module ddrs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int PTR_W = 3,
  parameter int CNT_W = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CNT_W-1:0] level
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [CNT_W-1:0] cnt;
  } ddrs_fifo_st_t;

  ddrs_fifo_st_t st_r;
  ddrs_fifo_st_t st_nxt;
  logic push;
  logic pop;

  assign in_ready = (st_r.cnt != CNT_W'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data = st_r.mem[st_r.rptr];
  assign level = st_r.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wptr] = in_data;
      st_nxt.wptr = st_r.wptr + PTR_W'(1);
    end
    if (pop) begin
      st_nxt.rptr = st_r.rptr + PTR_W'(1);
    end
    st_nxt.cnt = st_r.cnt + CNT_W'(push) - CNT_W'(pop);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== tb/ddrs_chk.sv
// ddrs_chk: pin assertions for ddrs_sram_port
// assumes one clock, srst synchronous active high
`default_nettype none
module ddrs_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic single_clock_mode,
  input wire logic read_port_select_n,
  input wire logic read_data_oe,
  input wire logic input_phase_k_n,
  input wire logic write_room
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r;
  logic [3:0] idle_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 2'h0;
      idle_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + {1'b0, read_data_oe};
      idle_r <= !read_port_select_n ? 4'h0 : idle_r + {3'h0, idle_r != 4'hf};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_alt;
    $past(srst) == 1'b0 |-> input_phase_k_n != $past(input_phase_k_n);
  endproperty
  a_alt: assert property (p_alt) else $error("phase stuck");
  property p_rst_k;
    $past(srst) |-> !input_phase_k_n && !write_room;
  endproperty
  a_rst_k: assert property (p_rst_k) else $error("bad state after reset");
  property p_room;
    $past(srst, 2) && !$past(srst) |-> write_room;
  endproperty
  a_room: assert property (p_room) else $error("no write room");
  property p_first_norm;
    read_data_oe && cnt_r == 2'h0 && !single_clock_mode |->
      $past(read_port_select_n, 4) == 1'b0 && $past(input_phase_k_n, 4) == 1'b0;
  endproperty
  a_first_norm: assert property (p_first_norm) else $error("read start");
  property p_first_single;
    read_data_oe && cnt_r == 2'h0 && single_clock_mode |->
      $past(read_port_select_n, 3) == 1'b0 && $past(input_phase_k_n, 3) == 1'b0;
  endproperty
  a_first_single: assert property (p_first_single) else $error("read start");
  property p_whole;
    read_data_oe && cnt_r != 2'h3 |=> read_data_oe;
  endproperty
  a_whole: assert property (p_whole) else $error("short burst");
  property p_release;
    idle_r >= 4'h7 |-> !read_data_oe;
  endproperty
  a_release: assert property (p_release) else $error("outputs not released");
  property p_rst_oe;
    $past(srst) |-> !read_data_oe;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("drive after reset");
endmodule
bind ddrs_sram_port ddrs_chk u_chk (.clk, .srst, .single_clock_mode, .read_port_select_n,
  .read_data_oe, .input_phase_k_n, .write_room);
`default_nettype wire

// ===== tb/ddrs_ctl.sv
// ddrs_ctl: controller model driving selects, address and write data
// assumes calls are made at a rising clock edge
`default_nettype none
module ddrs_ctl
  import ddrs_pkg::*;
(
  input wire logic clk,
  input wire logic input_phase_k_n,
  input wire logic write_room,
  output logic write_port_select_n,
  output logic read_port_select_n,
  output ddrs_pkg::ddrs_addr_t address,
  output ddrs_pkg::ddrs_word_t write_data,
  output ddrs_pkg::ddrs_lanes_t byte_lane_write_select_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    write_port_select_n = 1'b1;
    read_port_select_n = 1'b1;
    address = '0;
    write_data = '0;
    byte_lane_write_select_n = '0;
  end
  // unselected lines keep changing
  task automatic idle(input int n);
    repeat (n) begin
      address <= ~address;
      write_data <= ~write_data;
      @(posedge clk);
    end
  endtask
  task automatic op(input logic w, input ddrs_addr_t a, input logic [3:0][DATA_W-1:0] d,
                    input logic [3:0][LANES-1:0] s);
    while (input_phase_k_n !== 1'b1 || (w && write_room !== 1'b1)) idle(1);
    for (int i = 0; i < 4; i++) begin
      write_port_select_n <= !(w && i == 0);
      read_port_select_n <= !(!w && i == 0);
      address <= i == 0 ? a : ~address;
      write_data <= w ? d[i] : ~write_data;
      byte_lane_write_select_n <= s[i];
      @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// tb: self-checking bench for ddrs_sram_port
// assumes ddrs_ctl drives the port and ddrs_chk is bound to it
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ddrs_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic single_clock_mode = 1'b0;
  logic write_port_select_n, read_port_select_n, read_data_oe, input_phase_k_n, write_room;
  ddrs_addr_t address;
  ddrs_word_t write_data, read_data, e;
  ddrs_lanes_t byte_lane_write_select_n;
  ddrs_word_t mem [ARRAY_WORDS] = '{default: '0};
  ddrs_word_t expq [$];
  int mismatches = 0;
  int checks_done = 0;
  int seed = 86565;
  ddrs_sram_port u_dut (.clk, .srst, .single_clock_mode, .write_port_select_n,
    .read_port_select_n, .address, .write_data, .byte_lane_write_select_n, .read_data,
    .read_data_oe, .input_phase_k_n, .write_room);
  ddrs_ctl u_ctl (.clk, .input_phase_k_n, .write_room, .write_port_select_n,
    .read_port_select_n, .address, .write_data, .byte_lane_write_select_n);
  initial forever #2 clk = ~clk;
  task automatic complete_run();
    if (expq.size() != 0) mismatches++;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic access(input logic w, input int slot);
    ddrs_addr_t a;
    logic [3:0][DATA_W-1:0] d;
    logic [3:0][LANES-1:0] s;
    a = ddrs_addr_t'($random(seed));
    a[1:0] = slot[1:0];
    foreach (d[i]) d[i] = DATA_W'($random(seed));
    s = $bits(s)'($random(seed));
    for (int i = 0; i < 4; i++) begin
      for (int l = 0; l < LANES; l++)
        if (w && !s[i][l]) mem[slot * 4 + i][l * LANE_W +: LANE_W] = d[i][l * LANE_W +: LANE_W];
      if (!w) expq.push_back(mem[slot * 4 + i]);
    end
    u_ctl.op(w, a, d, s);
  endtask
  always @(posedge clk) begin
    if (read_data_oe === 1'b1) begin
      e = expq.size() != 0 ? expq.pop_front() : 'x;
      checks_done++;
      if (read_data !== e) begin
        mismatches++;
        $display("MISMATCH t=%0t got %h exp %h", $time, read_data, e);
      end
    end
  end
  initial begin
    #(4 * 3000);
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      single_clock_mode <= m[0];
      @(posedge clk);
      for (int k = 0; k < 12; k++) access(k >= 4 && k < 8, k % 4);
      u_ctl.idle(16);
      for (int k = 0; k < 4; k++) access(1'b0, 3 - k);
      u_ctl.idle(10);
      $display("mode %0d done", m);
    end
    complete_run();
  end
endmodule
`default_nettype wire
